// file: hw/mas_pkg.sv
// Shared constants and types for the monitoring converter sequencer
package mas_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_RESULT_UPPER = 8'h07;
  localparam logic [7:0] OFS_RESULT_LOWER = 8'h08;
  localparam logic [7:0] OFS_CONV_CTRL    = 8'h09;
  localparam logic [7:0] OFS_CHAN_READY   = 8'h0a;

  // ==========================================================
  // Field positions in the control register
  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_ONESHOT_BIT = 1;
  localparam int CTRL_SCAN_BIT    = 2;
  localparam int CTRL_BUFDIS_BIT  = 3;

  // Field positions in the channel and ready register
  localparam int CONV_CH_LSB   = 0;
  localparam int READ_CH_LSB   = 4;
  localparam int READY_BIT     = 7;
  localparam int CH_WIDTH      = 3;

  // Result placement inside the two read-only bytes
  localparam int UPPER_SRC_LSB = 4;
  localparam int LOWER_SRC_MSB = 3;

  // ==========================================================
  // Converter geometry and reset values
  localparam int RESULT_WIDTH  = 12;
  localparam int NUM_CHANNELS  = 7;
  localparam logic [2:0] LAST_CHANNEL = 3'h6;
  localparam logic [2:0] FIRST_CHANNEL = 3'h0;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  localparam logic       RESET_BIT    = 1'b0;

  // Channel codes of both channel fields
  typedef enum logic [2:0] {
    CH_INPUT_CURRENT  = 3'b000,
    CH_INPUT_VOLTAGE  = 3'b001,
    CH_OUTPUT_CURRENT = 3'b010,
    CH_OUTPUT_VOLTAGE = 3'b011,
    CH_THERMISTOR     = 3'b100,
    CH_DIE_TEMP       = 3'b101,
    CH_EXTERNAL       = 3'b110
  } mas_channel_type;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_WAIT  = 2'b10
  } mas_state_type;

endpackage

// file: hw/mas_result_file.sv
// Per-channel result storage with a registered read port
module mas_result_file #(
  parameter int DEPTH = 7,
  parameter int WIDTH = 12
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic             wrEn,
  input  wire logic [2:0]       wrIdx,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [2:0]       rdIdx,
  output logic      [WIDTH-1:0] rdData
);

  logic [WIDTH-1:0] slot_reg [DEPTH];

  // ==========================================================
  // One result register per channel, out-of-range writes dropped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_reg[i] <= '0;
      end
    end else if (clkEn && wrEn && (int'(wrIdx) < DEPTH)) begin
      slot_reg[wrIdx] <= wrData;
    end
  end

  // Seven-to-one selector into a read register, unused code reads zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rdData <= '0;
    end else if (clkEn) begin
      rdData <= (int'(rdIdx) < DEPTH) ? slot_reg[rdIdx] : '0;
    end
  end

endmodule

// file: hw/mas_adc_seq.sv
// Converter sequencer with control registers, result mapping and interrupt
// Summary of operation
// [RULE1] One 12-bit converter, multiplexer picks one of seven channels per conversion.
// [RULE2] Each channel result kept separately; one selected into the register map.
// [RULE3] Converter enable bit in control register 0x09 starts and stops conversions.
// [RULE4] Host selects single-shot: one-shot 1, scan 0, buffer-disable 0.
// [RULE5] Single-shot converts conversion-channel field; read-channel field picks exposed result.
// [RULE6] Host sets read channel equal to conversion channel in single-shot.
// [RULE7] Writing enable 1 starts a single-shot conversion of selected channel.
// [RULE8] Single-shot end sets ready, drives interrupt low, clears enable.
// [RULE9] Result high bits at 0x07, low bits at 0x08.
// [RULE10] Interrupt low and ready set held until result is read; the code also clears ready when enable is written to 1 from 0.
// [RULE11] Reading the result releases the interrupt by itself.
// [RULE12] Host repeats by rewriting enable; changes channels first for another input.
// [RULE13] Host selects polling: one-shot 0, scan 1, buffer-disable 0.
// [RULE14] Polling begins when enable is written to 1.
// [RULE15] Polling steps through all channels continuously, overwriting each result.
// [RULE16] Polling sets ready once every channel has been converted.
// [RULE17] Polling never drives the interrupt low.
// [RULE18] Host checks ready before reading polling results.
// [RULE19] Host picks exposed polling channel with the read-channel field.
// [RULE20] Channel codes 000 to 110 map to the seven monitored inputs.
// [RULE21] Clearing enable during polling stops after the conversion in progress.
module mas_adc_seq #(
  parameter int RESULT_WIDTH = mas_pkg::RESULT_WIDTH,
  parameter int NUM_CHANNELS = mas_pkg::NUM_CHANNELS
) (
  input  wire logic                    clk_sys,
  input  wire logic                    sys_rst,
  input  wire logic                    clkEn,
  input  wire logic                    regWrEn,
  input  wire logic                    regRdEn,
  input  wire logic [7:0]              regAddr,
  input  wire logic [7:0]              regWrData,
  output logic      [7:0]              regRdData,
  output logic                         convStart,
  output logic      [2:0]              convChannel,
  input  wire logic                    convDone,
  input  wire logic [RESULT_WIDTH-1:0] convData,
  output logic                         inputBufferDisable,
  output logic                         interruptOutN
);

  // ==========================================================
  // Declarations
  mas_pkg::mas_state_type state_reg;
  mas_pkg::mas_state_type state_next;

  logic                    convEnable_reg;
  logic                    oneShot_reg;
  logic                    channelScanSelect_reg;
  logic                    inputBufferDisable_reg;
  logic [2:0]              conversionChannel_reg;
  logic [2:0]              readbackChannel_reg;
  logic                    dataReady_reg;
  logic                    irqPending_reg;
  logic [2:0]              pollChannel_reg;
  logic [2:0]              activeChannel_reg;
  logic                    activePoll_reg;
  logic                    convStart_reg;
  logic [RESULT_WIDTH-1:0] readWord;

  logic ctrlWrite;
  logic chanWrite;
  logic resultRead;
  logic singleMode;
  logic pollMode;
  logic launch;
  logic finish;
  logic finishSingle;
  logic finishPoll;
  logic sweepDone;
  logic pollRestart;

  // ==========================================================
  // Decode of register accesses and mode
  assign ctrlWrite  = regWrEn && (regAddr == mas_pkg::OFS_CONV_CTRL);
  assign chanWrite  = regWrEn && (regAddr == mas_pkg::OFS_CHAN_READY);
  assign resultRead = regRdEn && ((regAddr == mas_pkg::OFS_RESULT_UPPER) ||
                                  (regAddr == mas_pkg::OFS_RESULT_LOWER));
  assign singleMode = oneShot_reg && !channelScanSelect_reg;
  assign pollMode   = !oneShot_reg && channelScanSelect_reg;

  // Conversion launch and completion events
  assign launch       = (state_reg == mas_pkg::ST_IDLE) && convEnable_reg &&
                        (singleMode || pollMode); // [RULE7] [RULE14] [RULE21]
  assign finish       = (state_reg == mas_pkg::ST_WAIT) && convDone;
  assign finishSingle = finish && !activePoll_reg;
  assign finishPoll   = finish && activePoll_reg;
  assign sweepDone    = finishPoll && (activeChannel_reg == mas_pkg::LAST_CHANNEL);
  assign pollRestart  = ctrlWrite && regWrData[mas_pkg::CTRL_ENABLE_BIT] && !convEnable_reg;

  // ==========================================================
  // Sequencer state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      mas_pkg::ST_IDLE: begin
        if (launch) begin
          state_next = mas_pkg::ST_START;
        end
      end
      mas_pkg::ST_START: begin
        state_next = mas_pkg::ST_WAIT;
      end
      mas_pkg::ST_WAIT: begin
        if (convDone) begin
          state_next = mas_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = mas_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= mas_pkg::ST_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // Channel and mode latched at launch, held through the conversion
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      activeChannel_reg <= mas_pkg::FIRST_CHANNEL;
      activePoll_reg    <= mas_pkg::RESET_BIT;
    end else if (clkEn && launch) begin
      activeChannel_reg <= pollMode ? pollChannel_reg : conversionChannel_reg; // [RULE5] [RULE15]
      activePoll_reg    <= pollMode;
    end
  end

  // One-cycle start pulse to the converter
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      convStart_reg <= mas_pkg::RESET_BIT;
    end else if (clkEn) begin
      convStart_reg <= (state_next == mas_pkg::ST_START); // [RULE1]
    end
  end

  assign convStart   = convStart_reg;
  assign convChannel = activeChannel_reg; // [RULE1] [RULE20]

  // Polling channel walks 0..6 and wraps
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pollChannel_reg <= mas_pkg::FIRST_CHANNEL;
    end else if (clkEn) begin
      if (pollRestart) begin
        pollChannel_reg <= mas_pkg::FIRST_CHANNEL; // [RULE14]
      end else if (finishPoll) begin
        pollChannel_reg <= (activeChannel_reg == mas_pkg::LAST_CHANNEL) ?
                           mas_pkg::FIRST_CHANNEL : activeChannel_reg + 3'h1; // [RULE15]
      end
    end
  end

  // ==========================================================
  // Control register; software set wins over the hardware clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      convEnable_reg         <= mas_pkg::RESET_BIT;
      oneShot_reg            <= mas_pkg::RESET_BIT;
      channelScanSelect_reg  <= mas_pkg::RESET_BIT;
      inputBufferDisable_reg <= mas_pkg::RESET_BIT;
    end else if (clkEn) begin
      if (ctrlWrite) begin
        convEnable_reg         <= regWrData[mas_pkg::CTRL_ENABLE_BIT]; // [RULE3]
        oneShot_reg            <= regWrData[mas_pkg::CTRL_ONESHOT_BIT];
        channelScanSelect_reg  <= regWrData[mas_pkg::CTRL_SCAN_BIT];
        inputBufferDisable_reg <= regWrData[mas_pkg::CTRL_BUFDIS_BIT];
      end else if (finishSingle) begin
        convEnable_reg <= 1'b0; // [RULE8]
      end
    end
  end

  assign inputBufferDisable = inputBufferDisable_reg;

  // Channel fields
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      conversionChannel_reg <= mas_pkg::FIRST_CHANNEL;
      readbackChannel_reg   <= mas_pkg::FIRST_CHANNEL;
    end else if (clkEn && chanWrite) begin
      conversionChannel_reg <= regWrData[mas_pkg::CONV_CH_LSB +: mas_pkg::CH_WIDTH]; // [RULE5]
      readbackChannel_reg   <= regWrData[mas_pkg::READ_CH_LSB +: mas_pkg::CH_WIDTH]; // [RULE5]
    end
  end

  // ==========================================================
  // Ready flag: set on single completion or full sweep, set wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dataReady_reg <= mas_pkg::RESET_BIT;
    end else if (clkEn) begin
      if (finishSingle || sweepDone) begin
        dataReady_reg <= 1'b1; // [RULE8] [RULE16]
      end else if (pollRestart || (resultRead && !activePoll_reg)) begin
        dataReady_reg <= 1'b0; // [RULE10]
      end
    end
  end

  // Interrupt pending only from single-shot completion
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irqPending_reg <= mas_pkg::RESET_BIT;
    end else if (clkEn) begin
      if (finishSingle) begin
        irqPending_reg <= 1'b1; // [RULE8] [RULE17]
      end else if (resultRead) begin
        irqPending_reg <= 1'b0; // [RULE11]
      end
    end
  end

  assign interruptOutN = !irqPending_reg; // [RULE10]

  // ==========================================================
  // Result storage and selector
  mas_result_file #(
    .DEPTH (NUM_CHANNELS),
    .WIDTH (RESULT_WIDTH)
  ) mas_result_file_i (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .wrEn    (finish),
    .wrIdx   (activeChannel_reg),
    .wrData  (convData),
    .rdIdx   (readbackChannel_reg),
    .rdData  (readWord)
  ); // [RULE2]

  // Register read mux, unmapped offsets read zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regRdData <= mas_pkg::RESET_BYTE;
    end else if (clkEn && regRdEn) begin
      unique case (regAddr)
        mas_pkg::OFS_RESULT_UPPER: begin
          regRdData <= readWord[RESULT_WIDTH-1:mas_pkg::UPPER_SRC_LSB]; // [RULE9]
        end
        mas_pkg::OFS_RESULT_LOWER: begin
          regRdData <= {4'h0, readWord[mas_pkg::LOWER_SRC_MSB:0]}; // [RULE9]
        end
        mas_pkg::OFS_CONV_CTRL: begin
          regRdData <= {4'h0, inputBufferDisable_reg, channelScanSelect_reg,
                        oneShot_reg, convEnable_reg};
        end
        mas_pkg::OFS_CHAN_READY: begin
          regRdData <= {dataReady_reg, readbackChannel_reg, 1'b0, conversionChannel_reg};
        end
        default: begin
          regRdData <= mas_pkg::RESET_BYTE;
        end
      endcase
    end
  end

  // ==========================================================
  // Assertions
  a_launch_channel: assert property ( // [RULE1]
    @(posedge clk_sys) disable iff (sys_rst)
    convStart |-> (convChannel != 3'h7 || !activePoll_reg))
    else $error("polling converts an unused channel code");

  a_start_pulse: assert property ( // [RULE1]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && convStart) |=> !convStart)
    else $error("start pulse longer than one cycle");

  a_channel_hold: assert property ( // [RULE1]
    @(posedge clk_sys) disable iff (sys_rst)
    (state_reg == mas_pkg::ST_WAIT) |=> $stable(convChannel))
    else $error("multiplexer select moved during a conversion");

  a_single_start: assert property ( // [RULE7]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && ctrlWrite && !convEnable_reg && state_reg == mas_pkg::ST_IDLE &&
     regWrData[3:0] == 4'h3) |=> ##1 convStart)
    else $error("single-shot enable write did not start a conversion");

  a_single_done: assert property ( // [RULE8]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && finishSingle && !ctrlWrite)
      |=> (dataReady_reg && !interruptOutN && !convEnable_reg))
    else $error("single-shot completion did not flag, interrupt and clear enable");

  a_irq_hold: assert property ( // [RULE10]
    @(posedge clk_sys) disable iff (sys_rst)
    (!interruptOutN && !resultRead) |=> !interruptOutN)
    else $error("interrupt released without a result read");

  a_ready_hold: assert property ( // [RULE10]
    @(posedge clk_sys) disable iff (sys_rst)
    (dataReady_reg && !resultRead && !pollRestart) |=> dataReady_reg)
    else $error("ready flag dropped without a result read");

  a_irq_release: assert property ( // [RULE11]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && resultRead && !finishSingle) |=> interruptOutN)
    else $error("result read did not release interrupt");

  a_poll_start: assert property ( // [RULE14]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && ctrlWrite && !convEnable_reg && state_reg == mas_pkg::ST_IDLE &&
     regWrData[3:0] == 4'h5) |=> ##1 (convStart && convChannel == 3'h0))
    else $error("polling enable write did not start at the first channel");

  a_poll_step: assert property ( // [RULE15]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && finishPoll && !pollRestart && activeChannel_reg != 3'h6)
      |=> (pollChannel_reg == $past(activeChannel_reg) + 3'h1))
    else $error("polling channel did not advance by one");

  a_sweep_ready: assert property ( // [RULE16]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && sweepDone) |=> (dataReady_reg && pollChannel_reg == 3'h0))
    else $error("full sweep did not set ready and wrap");

  a_poll_no_irq: assert property ( // [RULE17]
    @(posedge clk_sys) disable iff (sys_rst)
    $fell(interruptOutN) |-> $past(finishSingle))
    else $error("interrupt asserted without single-shot completion");

  a_poll_irq_quiet: assert property ( // [RULE17]
    @(posedge clk_sys) disable iff (sys_rst)
    (activePoll_reg && interruptOutN) |=> interruptOutN)
    else $error("interrupt asserted during polling");

  a_enable_stop: assert property ( // [RULE21]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && state_reg == mas_pkg::ST_IDLE && !convEnable_reg) |=> !convStart)
    else $error("conversion started with enable cleared");

  a_upper_map: assert property ( // [RULE9]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && regRdEn && regAddr == 8'h07) |=> (regRdData == $past(readWord[11:4])))
    else $error("upper result byte misplaced");

  a_lower_map: assert property ( // [RULE9]
    @(posedge clk_sys) disable iff (sys_rst)
    (clkEn && regRdEn && regAddr == 8'h08) |=> (regRdData == {4'h0, $past(readWord[3:0])}))
    else $error("lower result byte misplaced");

  c_single_done: cover property (@(posedge clk_sys) finishSingle);
  c_full_sweep:  cover property (@(posedge clk_sys) sweepDone);
  c_irq_cleared: cover property (@(posedge clk_sys) $rose(interruptOutN));
  c_poll_stop:   cover property (@(posedge clk_sys) finishPoll ##1 !convEnable_reg);
  c_code_unused: cover property (@(posedge clk_sys) finishSingle && activeChannel_reg == 3'h7);

endmodule

// file: test/mas_conv_model.sv
// Behavioural converter answering start pulses with a channel-tagged result
module mas_conv_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        convStart,
  input  wire logic [2:0]  convChannel,
  input  wire logic [3:0]  bias,
  input  wire logic [3:0]  lat,
  output logic             convDone,
  output logic      [11:0] convData
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt;
  logic       busy;
  logic [2:0] ch;

  // ==========================================================
  // Conversion timing; data toggles while not valid
  always_ff @(posedge clk_sys) begin
    convDone <= 1'b0;
    convData <= ~convData;
    if (sys_rst) begin
      busy     <= 1'b0;
      convData <= 12'h000;
    end else if (convStart) begin
      busy <= 1'b1;
      cnt  <= lat;
      ch   <= convChannel;
    end else if (busy) begin
      if (cnt == 4'h0) begin
        busy     <= 1'b0;
        convDone <= 1'b1;
        convData <= {ch, bias, 2'b10, ch};
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// file: test/mas_adc_seq_tb.sv
// Self-checking bench for the monitoring converter sequencer
module mas_adc_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clkEn = 1'b1;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [7:0]  regWrData = 8'h00;
  logic [7:0]  regRdData;
  logic        convStart;
  logic [2:0]  convChannel;
  logic        convDone;
  logic [11:0] convData;
  logic        inputBufferDisable;
  logic        interruptOutN;
  logic [3:0]  bias = 4'h0;
  logic [3:0]  lat = 4'h0;
  logic        pollOn = 1'b0;
  logic [2:0]  nextCh = 3'h0;
  logic [2:0]  lastCh = 3'h0;
  int          startCount = 0;
  int          errors = 0;
  int          checksDone = 0;

  // ==========================================================
  // Clock and instances
  always #2 clk_sys = ~clk_sys;

  mas_adc_seq mas_adc_seq_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .convStart(convStart), .convChannel(convChannel), .convDone(convDone),
    .convData(convData), .inputBufferDisable(inputBufferDisable),
    .interruptOutN(interruptOutN)
  );

  mas_conv_model mas_conv_model_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .convStart(convStart),
    .convChannel(convChannel), .bias(bias), .lat(lat), .convDone(convDone),
    .convData(convData)
  );

  // ==========================================================
  // Compare tasks and register access
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checksDone++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chkBit(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys) begin
      regWrEn   = 1'b1;
      regAddr   = a;
      regWrData = d;
    end
    @(negedge clk_sys) regWrEn = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    @(negedge clk_sys) begin
      regRdEn = 1'b1;
      regAddr = a;
    end
    @(negedge clk_sys) regRdEn = 1'b0;
    d = regRdData;
  endtask

  function automatic logic [11:0] expData(input logic [2:0] c, input logic [3:0] b);
    return {c, b, 2'b10, c};
  endfunction

  task tally_and_finish;
    $display("Checks %0d, errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // Monitors of launched channels and the interrupt line, sampled mid-cycle
  always @(negedge clk_sys) begin
    if (convStart === 1'b1) begin
      startCount++;
      lastCh = convChannel;
      if (pollOn) begin
        chk({5'h00, convChannel}, {5'h00, nextCh}, "poll channel");
        nextCh = (nextCh == 3'h6) ? 3'h0 : nextCh + 3'h1;
      end
    end
  end

  always @(negedge clk_sys) begin
    if (pollOn && interruptOutN !== 1'b1) chkBit(interruptOutN, 1'b1, "poll irq");
  end

  // ==========================================================
  // Test sequence
  initial begin
    logic [7:0]  d;
    logic [11:0] e;
    logic [2:0]  c;
    int          n;
    int          k;
    fork
      begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        tally_and_finish();
      end
    join_none
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys) sys_rst = 1'b0;
    chk(regRdData, 8'h00, "reset data");
    chkBit(interruptOutN, 1'b1, "reset irq");
    chkBit(convStart, 1'b0, "reset start");
    chkBit(inputBufferDisable, 1'b0, "reset bufdis");
    rd(mas_pkg::OFS_CONV_CTRL, d);
    chk(d, 8'h00, "ctrl reset");
    rd(mas_pkg::OFS_CHAN_READY, d);
    chk(d, 8'h00, "chan reset");
    rd(8'h20, d);
    chk(d, 8'h00, "unmapped");
    // A write with the clock enable low must leave the control register frozen
    clkEn = 1'b0;
    wr(mas_pkg::OFS_CONV_CTRL, 8'h0f);
    clkEn = 1'b1;
    rd(mas_pkg::OFS_CONV_CTRL, d);
    chk(d, 8'h00, "frozen ctrl");
    wr(mas_pkg::OFS_CONV_CTRL, 8'h08);
    rd(mas_pkg::OFS_CONV_CTRL, d);
    chk(d, 8'h08, "bufdis");
    chkBit(inputBufferDisable, 1'b1, "bufdis pin");
    // Both mode bits set: enable kept, nothing launched
    n = startCount;
    wr(mas_pkg::OFS_CONV_CTRL, 8'h07);
    repeat (20) @(negedge clk_sys);
    chk(8'(startCount - n), 8'h00, "bad mode idle");
    rd(mas_pkg::OFS_CONV_CTRL, d);
    chk(d, 8'h07, "bad mode kept");
    // Single-shot on channel codes 0 to 6 with growing latency
    for (int i = 0; i < 7; i++) begin
      c    = 3'(i);
      bias = 4'(i + 1);
      lat  = 4'(i * 2);
      wr(mas_pkg::OFS_CHAN_READY, {1'b0, c, 1'b0, c});
      wr(mas_pkg::OFS_CONV_CTRL, 8'h03);
      n = 0;
      while (interruptOutN !== 1'b0 && n < 100) begin
        @(negedge clk_sys);
        n++;
      end
      chkBit(interruptOutN, 1'b0, "irq low");
      chk({5'h00, lastCh}, {5'h00, c}, "conv channel");
      rd(mas_pkg::OFS_CONV_CTRL, d);
      chk(d, 8'h02, "enable clear");
      rd(mas_pkg::OFS_CHAN_READY, d);
      chk(d, {1'b1, c, 1'b0, c}, "ready");
      chkBit(interruptOutN, 1'b0, "irq held");
      wr(mas_pkg::OFS_RESULT_UPPER, 8'hff);
      e = expData(c, bias);
      rd(mas_pkg::OFS_RESULT_UPPER, d);
      chk(d, e[11:4], "upper");
      chkBit(interruptOutN, 1'b1, "irq release");
      rd(mas_pkg::OFS_RESULT_LOWER, d);
      chk(d, {4'h0, e[3:0]}, "lower");
    end
    // Unused channel code converts, but its result reads as zero
    wr(mas_pkg::OFS_CHAN_READY, 8'h77);
    wr(mas_pkg::OFS_CONV_CTRL, 8'h03);
    n = 0;
    while (interruptOutN !== 1'b0 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    chkBit(interruptOutN, 1'b0, "code7 irq");
    rd(mas_pkg::OFS_RESULT_UPPER, d);
    chk(d, 8'h00, "code7 upper");
    chkBit(interruptOutN, 1'b1, "code7 release");
    rd(mas_pkg::OFS_RESULT_LOWER, d);
    chk(d, 8'h00, "code7 lower");
    // Automatic polling, overwrite, then stop
    lat    = 4'h1;
    bias   = 4'h3;
    pollOn = 1'b1;
    wr(mas_pkg::OFS_CONV_CTRL, 8'h05);
    d = 8'h00;
    n = 0;
    while (d[7] !== 1'b1 && n < 100) begin
      rd(mas_pkg::OFS_CHAN_READY, d);
      n++;
    end
    chkBit(d[7], 1'b1, "poll ready");
    bias = 4'hc;
    n = startCount;
    k = 0;
    while (startCount < n + 8 && k < 500) begin
      @(negedge clk_sys);
      k++;
    end
    wr(mas_pkg::OFS_CONV_CTRL, 8'h04);
    repeat (40) @(negedge clk_sys);
    n = startCount;
    repeat (40) @(negedge clk_sys);
    chk(8'(startCount - n), 8'h00, "stopped");
    pollOn = 1'b0;
    for (int i = 0; i < 7; i++) begin
      c = 3'(i);
      e = expData(c, 4'hc);
      wr(mas_pkg::OFS_CHAN_READY, {1'b0, c, 4'h0});
      rd(mas_pkg::OFS_RESULT_UPPER, d);
      chk(d, e[11:4], "poll upper");
      rd(mas_pkg::OFS_RESULT_LOWER, d);
      chk(d, {4'h0, e[3:0]}, "poll lower");
    end
    tally_and_finish();
  end
endmodule
